// ---- swd_timeout_regs.svh ----
// timing counts and reset values for the single-wire debug timeout logic
// assumes all counts are in cycles of the serial debug clock
`ifndef SWD_TIMEOUT_REGS_SVH
`define SWD_TIMEOUT_REGS_SVH

// low time beyond which a host low pulse is a sync request
`define SWD_SYNC_LOW_CYC 128
// longest gap between falling edges while a transfer is open
`define SWD_GAP_TIMEOUT_CYC 512
// pause after the host releases, before the sync answer
`define SWD_SYNC_DELAY_CYC 16
// length of the driven low part of the sync answer
`define SWD_SYNC_DRIVE_CYC 128
// handshake protocol state after reset (off)
`define SWD_HANDSHAKE_RST 1'b0

`endif

// ---- swd_timeout_pkg.sv ----
// types shared by the single-wire debug timeout logic
// assumes the timing header is compiled alongside
package swd_timeout_pkg;

  // link supervisor states
  typedef enum logic [2:0] {
    ST_IDLE,        // waiting for a first falling edge
    ST_LOW,         // host holds the wire low
    ST_GAP,         // wire high between bits
    ST_SYNC_WAIT,   // sync seen, waiting for release
    ST_SYNC_DELAY,  // pause before answering
    ST_SYNC_DRIVE,  // answer: wire driven low
    ST_SYNC_PULSE   // answer: one-cycle high speedup
  } link_state_t;

  // status from the command layer
  typedef struct packed {
    logic xfer_partial;  // command or retrieval under way
    logic read_issued;   // pulse: read command taken
    logic ack_issued;    // pulse: acknowledge pulse sent
    logic ack_pending;   // an acknowledge is still owed
    logic hs_enable;     // pulse: handshake switched on
    logic hs_disable;    // pulse: handshake switched off
  } cmd_status_t;

  // one-cycle events back to the command layer
  typedef struct packed {
    logic soft_reset;   // drop pending command or read
    logic sync_detect;  // sync request recognised
    logic bit_valid;    // a normal bit low period ended
    logic ack_cancel;   // pending acknowledge aborted
  } link_events_t;

endpackage

// ---- swd_cycle_counter.sv ----
// saturating cycle counter with synchronous restart
// assumes a single clock and an active-low asynchronous reset
`timescale 1ns/10ps

module swd_cycle_counter #(
  parameter int WIDTH = 10
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_restart,
  // count value
  output logic [WIDTH-1:0] o_count
);

  logic [WIDTH-1:0] count_reg; // cycles since last restart
  logic [WIDTH-1:0] count_next;

  // refuse widths the saturation test cannot serve
  if (WIDTH < 2)
  begin : g_bad_width
    $error("counter width too small");
  end

  // restart wins; otherwise count up and hold at the top
  always_comb
  begin
    count_next = count_reg;
    if (i_restart)
      count_next = '0;
    else if (count_reg != {WIDTH{1'b1}})
      count_next = count_reg + WIDTH'(1);
  end

  // plain register stage
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign o_count = count_reg;

endmodule // swd_cycle_counter

// ---- swd_link_supervisor.sv ----
// sync detection, sync answer and soft-reset timeout for the target end
// of the single-wire debug link; runs on the serial debug clock
// assumes the wire input is already synchronous to i_core_clk
//
// Notes on behaviour
// - low beyond 128 cycles is a sync request
// - after sync, wait for release without limit
// - release before 128 cycles is one bit
// - no falling edge within 512 cycles while a transfer or read is open: soft reset
// - handshake off: unretrieved read times out
// - handshake on: read wait timeout suspended
// - acknowledge pulse re-arms the 512 cycle timeout
// - after soft reset, next edge starts anew
// - partial transfer keeps the gap timeout armed
// - answer: wait high, 16 pause, 128 low, pulse
// - handshake protocol off after reset
// - sync cancels a pending acknowledge pulse
`timescale 1ns/10ps
`include "swd_timeout_regs.svh"

module swd_link_supervisor #(
  parameter int SYNC_LOW_CYC = `SWD_SYNC_LOW_CYC,
  parameter int GAP_TIMEOUT_CYC = `SWD_GAP_TIMEOUT_CYC,
  parameter int SYNC_DELAY_CYC = `SWD_SYNC_DELAY_CYC,
  parameter int SYNC_DRIVE_CYC = `SWD_SYNC_DRIVE_CYC,
  parameter int PHASE_W = 8,
  parameter int GAP_W = 10
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // debug wire, split into level, drive value and enable
  input wire logic i_debug_wire_pin,
  output logic o_debug_wire_out,
  output logic o_debug_wire_oe,
  // command layer
  input swd_timeout_pkg::cmd_status_t i_cmd,
  output swd_timeout_pkg::link_events_t o_events,
  output logic [PHASE_W-1:0] o_bit_low_len,
  output logic o_handshake_on
);
  import swd_timeout_pkg::*;

  localparam logic [PHASE_W-1:0] SYNC_LOW = PHASE_W'(SYNC_LOW_CYC);
  localparam logic [PHASE_W-1:0] DELAY_END = PHASE_W'(SYNC_DELAY_CYC - 1);
  localparam logic [PHASE_W-1:0] DRIVE_END = PHASE_W'(SYNC_DRIVE_CYC - 1);
  localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(GAP_TIMEOUT_CYC);

  // refuse widths that cannot reach the counts
  if ((2 ** PHASE_W) - 1 <= SYNC_LOW_CYC ||
      (2 ** PHASE_W) < SYNC_DRIVE_CYC || SYNC_DELAY_CYC < 1 ||
      SYNC_DRIVE_CYC < 1 || (2 ** GAP_W) - 1 <= GAP_TIMEOUT_CYC)
  begin : g_bad_widths
    $error("counter widths too narrow for the counts");
  end

  link_state_t state_reg; // supervisor state
  link_state_t state_next;
  logic pin_prev_reg; // wire level one cycle back
  logic hs_reg; // handshake protocol on
  logic hs_next;
  logic read_wait_reg; // read data not yet being retrieved
  logic read_wait_next;
  logic ack_seen_reg; // acknowledge sent for the waiting read
  logic ack_seen_next;
  link_events_t ev_reg; // registered event pulses
  link_events_t ev_next;
  logic [PHASE_W-1:0] len_reg; // low length of last bit
  logic [PHASE_W-1:0] len_next;
  logic [PHASE_W-1:0] phase_cnt; // cycles in current phase
  logic [GAP_W-1:0] gap_cnt; // cycles since last falling edge or acknowledge during a read wait
  logic fall; // host falling edge, ignored during the sync answer pause, drive and pulse
  logic responding; // sync answer in progress
  logic armed; // gap timeout may fire
  logic suspended; // handshake holds the read timeout
  logic timeout; // gap limit reached while armed
  logic phase_restart;
  logic gap_restart;

  assign responding = (state_reg == ST_SYNC_DELAY) ||
                      (state_reg == ST_SYNC_DRIVE) ||
                      (state_reg == ST_SYNC_PULSE);
  assign fall = pin_prev_reg && !i_debug_wire_pin && !responding;

  // read waits count only when not held by the handshake
  assign suspended = read_wait_reg && hs_reg && !ack_seen_reg;
  assign armed = i_cmd.xfer_partial || (read_wait_reg && !suspended);
  // a restart in the same cycle wins over the limit
  assign timeout = (state_reg == ST_GAP) && armed && !gap_restart &&
                   (gap_cnt >= GAP_LIMIT);

  // phase time restarts on every change of state or edge
  assign phase_restart = (state_next != state_reg) || fall;
  // the ack restart gives the host a fresh window to collect data
  assign gap_restart = fall || (i_cmd.ack_issued && read_wait_reg);

  // gap between falling edges
  swd_cycle_counter #(
    .WIDTH(GAP_W)
  ) u_gap_cnt (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_restart(gap_restart),
    .o_count(gap_cnt)
  );

  // time within a low pulse or sync answer step
  swd_cycle_counter #(
    .WIDTH(PHASE_W)
  ) u_phase_cnt (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_restart(phase_restart),
    .o_count(phase_cnt)
  );

  // next state of the wire supervisor
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      // fresh start after reset, soft reset or sync answer
      ST_IDLE:
      begin
        if (fall)
          state_next = ST_LOW;
      end
      // measure the host low time
      ST_LOW:
      begin
        if (i_debug_wire_pin)
          state_next = ST_GAP;
        else if (phase_cnt >= SYNC_LOW)
          state_next = ST_SYNC_WAIT;
      end
      // between bits; the timeout lives here
      ST_GAP:
      begin
        if (fall)
          state_next = ST_LOW;
        else if (timeout)
          state_next = ST_IDLE;
      end
      // no time limit on the host release
      ST_SYNC_WAIT:
      begin
        if (i_debug_wire_pin)
          state_next = ST_SYNC_DELAY;
      end
      // let the host speedup pulse die away
      ST_SYNC_DELAY:
      begin
        if (phase_cnt == DELAY_END)
          state_next = ST_SYNC_DRIVE;
      end
      // timed low reference for the host
      ST_SYNC_DRIVE:
      begin
        if (phase_cnt == DRIVE_END)
          state_next = ST_SYNC_PULSE;
      end
      // single high speedup cycle, then release
      ST_SYNC_PULSE:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // handshake mode, read tracking and event pulses
  always_comb
  begin
    hs_next = hs_reg;
    if (i_cmd.hs_enable)
      hs_next = 1'b1;
    else if (i_cmd.hs_disable)
      hs_next = 1'b0;
    ev_next = '0;
    ev_next.sync_detect = (state_reg == ST_LOW) &&
                          (state_next == ST_SYNC_WAIT);
    ev_next.ack_cancel = ev_next.sync_detect && i_cmd.ack_pending;
    ev_next.soft_reset = timeout;
    ev_next.bit_valid = (state_reg == ST_LOW) && (state_next == ST_GAP);
    len_next = ev_next.bit_valid ? phase_cnt : len_reg;
    // retrieval, timeout or sync end a read wait; a new read wins
    read_wait_next = read_wait_reg;
    ack_seen_next = ack_seen_reg;
    if (i_cmd.read_issued)
    begin
      read_wait_next = 1'b1;
      ack_seen_next = 1'b0;
    end
    else if (timeout || ev_next.sync_detect || fall)
    begin
      read_wait_next = 1'b0;
      ack_seen_next = 1'b0;
    end
    else if (i_cmd.ack_issued && read_wait_reg)
    begin
      ack_seen_next = 1'b1;
    end
  end

  // register stage for all supervisor state
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg <= ST_IDLE;
      pin_prev_reg <= 1'b1;
      hs_reg <= `SWD_HANDSHAKE_RST;
      read_wait_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
      ev_reg <= '0;
      len_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      pin_prev_reg <= i_debug_wire_pin;
      hs_reg <= hs_next;
      read_wait_reg <= read_wait_next;
      ack_seen_reg <= ack_seen_next;
      ev_reg <= ev_next;
      len_reg <= len_next;
    end
  end

  // drive only during the answer; low first, then one high cycle
  assign o_debug_wire_oe = (state_reg == ST_SYNC_DRIVE) ||
                           (state_reg == ST_SYNC_PULSE);
  assign o_debug_wire_out = (state_reg == ST_SYNC_PULSE);
  assign o_events = ev_reg;
  assign o_bit_low_len = len_reg;
  assign o_handshake_on = hs_reg;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  chk_sync_classify: assert property (
    (state_reg == ST_LOW && !i_debug_wire_pin && phase_cnt == SYNC_LOW)
    |=> (state_reg == ST_SYNC_WAIT && o_events.sync_detect))
    else $error("long low not classified as sync");

  chk_sync_wait_hold: assert property (
    (state_reg == ST_SYNC_WAIT && !i_debug_wire_pin)
    |=> (state_reg == ST_SYNC_WAIT && !o_debug_wire_oe))
    else $error("sync wait left while wire low");

  chk_bit_accept: assert property (
    (state_reg == ST_LOW && i_debug_wire_pin)
    |=> (o_events.bit_valid && state_reg == ST_GAP
         && !o_events.sync_detect))
    else $error("short low not taken as a bit");

  chk_gap_timeout: assert property (
    (state_reg == ST_GAP && armed && !gap_restart && gap_cnt == GAP_LIMIT)
    |=> (o_events.soft_reset && state_reg == ST_IDLE))
    else $error("gap timeout did not soft reset");

  chk_read_suspend: assert property (
    (suspended && !i_cmd.xfer_partial) |=> !o_events.soft_reset)
    else $error("timeout fired during handshake wait");

  chk_ack_rearm: assert property (
    (i_cmd.ack_issued && read_wait_reg && !i_cmd.xfer_partial
     && state_reg == ST_GAP)
    |=> (gap_cnt == '0 && !o_events.soft_reset))
    else $error("acknowledge did not re-arm timeout");

  chk_idle_restart: assert property (
    (state_reg == ST_IDLE && fall) |=> (state_reg == ST_LOW))
    else $error("edge after soft reset not taken");

  chk_answer_shape: assert property (
    (state_reg == ST_SYNC_DRIVE && phase_cnt == DRIVE_END)
    |=> (o_debug_wire_oe && o_debug_wire_out)
    ##1 (!o_debug_wire_oe && state_reg == ST_IDLE))
    else $error("sync answer end malformed");

  chk_answer_start: assert property (
    $rose(state_reg == ST_SYNC_DRIVE)
    |-> (o_debug_wire_oe && !o_debug_wire_out)[*8])
    else $error("sync answer low not driven");

  chk_ack_cancel: assert property (
    (state_reg == ST_LOW && !i_debug_wire_pin && phase_cnt == SYNC_LOW
     && i_cmd.ack_pending) |=> o_events.ack_cancel)
    else $error("sync did not cancel pending acknowledge");

endmodule // swd_link_supervisor

// ---- debug_host_model.sv ----
// host debug adapter model on the far end of the single debug wire
// assumes an external pull-up holds the wire high when nobody drives it
`timescale 1ns/10ps

module debug_host_model (
  // clock
  input wire logic i_core_clk,
  // resolved wire level
  input wire logic i_debug_wire_pin,
  // host pulls the wire low
  output logic o_host_low
);
  // released at time zero
  initial o_host_low = 1'b0;

  // low pulse of n samples, then release to the pull-up
  task automatic drive_low(input int n);
    @(negedge i_core_clk);
    o_host_low = 1'b1;
    repeat (n) @(negedge i_core_clk);
    o_host_low = 1'b0;
  endtask

  // sync request, then time the answer; sampled mid-cycle to avoid races
  task automatic request_sync(input int n, output int pause,
                              output int low_len);
    pause = 0;
    low_len = 0;
    // speedup high is left to the pull-up rise
    drive_low(n);
    // bounded listen: a missing answer shows as 64
    while (pause < 64)
    begin
      @(negedge i_core_clk);
      if (i_debug_wire_pin === 1'b0)
        break;
      pause++;
    end
    low_len = 1;
    while (low_len < 64)
    begin
      @(negedge i_core_clk);
      if (i_debug_wire_pin !== 1'b0)
        break;
      low_len++;
    end
  endtask
endmodule // debug_host_model

// ---- test_single_wire_debug_timeout.sv ----
// self-checking bench for the link supervisor with a host model
// assumes shortened counts; command layer status driven by the bench
`timescale 1ns/10ps
`include "swd_timeout_regs.svh"

module test_single_wire_debug_timeout;
  import swd_timeout_pkg::*;
  // shortened counts keep the run brief
  localparam int SYNC_LOW = 8;
  localparam int GAP = 40;
  localparam int DELAY = 4;
  localparam int DRIVE = 8;
  logic i_core_clk, i_rst_b, host_low, oe, out, wire_lvl, hs_on;
  cmd_status_t cmd;
  link_events_t ev;
  logic [7:0] bit_len;
  logic [31:0] miscompares, n_checks, n_sr, n_sync, n_bit, n_cancel;
  int seed, pause, low_len;

  // pull-up wire, device drive wins while enabled
  assign wire_lvl = oe ? out : !host_low;

  swd_link_supervisor #(.SYNC_LOW_CYC(SYNC_LOW), .GAP_TIMEOUT_CYC(GAP),
    .SYNC_DELAY_CYC(DELAY), .SYNC_DRIVE_CYC(DRIVE)) u_swd_link_supervisor (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_debug_wire_pin(wire_lvl), .o_debug_wire_out(out),
    .o_debug_wire_oe(oe), .i_cmd(cmd), .o_events(ev),
    .o_bit_low_len(bit_len), .o_handshake_on(hs_on));

  debug_host_model u_debug_host_model (.i_core_clk(i_core_clk),
    .i_debug_wire_pin(wire_lvl), .o_host_low(host_low));

  // 20 MHz clock
  always #25 i_core_clk = !i_core_clk;

  // event pulse tallies
  always @(posedge i_core_clk)
  begin
    n_sr <= n_sr + (ev.soft_reset === 1'b1);
    n_sync <= n_sync + (ev.sync_detect === 1'b1);
    n_bit <= n_bit + (ev.bit_valid === 1'b1);
    n_cancel <= n_cancel + (ev.ack_cancel === 1'b1);
  end

  // whether a stalled gap must end in a soft reset
  function automatic logic sr_exp(logic part, logic rd, logic hs, logic ack);
    return part | (rd & !(hs & !ack));
  endfunction

  // low length reported for a bit seen low on n samples, edge counted 0
  function automatic logic [31:0] len_exp(int n);
    return n - 1;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // tallies cleared mid-cycle, away from the counting edge
  task automatic clr();
    @(negedge i_core_clk);
    {n_sr, n_sync, n_bit, n_cancel} = '0;
  endtask

  // one-cycle status pulse; levels are left alone
  task automatic pulse(input cmd_status_t p);
    @(negedge i_core_clk);
    cmd = cmd | p;
    @(negedge i_core_clk);
    cmd = cmd & ~p;
  endtask

  // quiet until just short of the limit, then exp soft resets
  task automatic expect_timeout(input logic [31:0] exp);
    repeat (GAP - 6) @(negedge i_core_clk);
    check("early_soft_reset", n_sr, 0);
    repeat (14) @(negedge i_core_clk);
    check("soft_reset", n_sr, exp);
  endtask

  // overall hang guard
  initial
  begin
    repeat (100000) @(negedge i_core_clk);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    seed = 84753;
    {miscompares, n_checks, n_sr, n_sync, n_bit, n_cancel} = '0;
    {i_core_clk, i_rst_b} = 2'b00;
    cmd = '0;
    repeat (20) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    check("handshake_rst", hs_on, `SWD_HANDSHAKE_RST);
    check("oe_rst", oe, 0);
    // random short bits with gaps under the limit, transfer open
    cmd.xfer_partial = 1'b1;
    clr();
    for (int i = 0; i < 12; i++)
    begin
      int n;
      n = 1 + $unsigned($random(seed)) % 7;
      u_debug_host_model.drive_low(n);
      repeat (1 + $unsigned($random(seed)) % (GAP - 12))
        @(negedge i_core_clk);
      check("bit_low_len", bit_len, len_exp(n));
    end
    // let the last bit pulse reach the tally
    repeat (2) @(negedge i_core_clk);
    check("bits", n_bit, 12);
    check("bits_no_sync", n_sync, 0);
    check("bits_no_reset", n_sr, 0);
    // partial transfer stalls
    clr();
    u_debug_host_model.drive_low(3);
    expect_timeout(sr_exp(1, 0, 0, 0));
    cmd.xfer_partial = 1'b0;
    // next edge is a fresh bit; nothing open, so no timeout
    clr();
    u_debug_host_model.drive_low(3);
    expect_timeout(sr_exp(0, 0, 0, 0));
    check("bit_after_reset", n_bit, 1);
    // unretrieved read, handshake off
    clr();
    u_debug_host_model.drive_low(3);
    pulse(6'b010000);
    expect_timeout(sr_exp(0, 1, 0, 0));
    // handshake on: suspended until the acknowledge
    pulse(6'b000010);
    check("handshake_on", hs_on, 1);
    clr();
    u_debug_host_model.drive_low(3);
    pulse(6'b010000);
    repeat (3 * GAP) @(negedge i_core_clk);
    check("suspended", n_sr, 0);
    pulse(6'b001000);
    expect_timeout(sr_exp(0, 1, 1, 1));
    // sync near the threshold and a long one cancelling an ack
    for (int i = 0; i < 2; i++)
    begin
      cmd.ack_pending = i[0];
      clr();
      u_debug_host_model.request_sync(i ? 2 * GAP : SYNC_LOW + 2, pause,
                                      low_len);
      check("sync", n_sync, 1);
      check("sync_wait_no_reset", n_sr, 0);
      check("cancel", n_cancel, i);
      check("pause", pause, DELAY);
      check("answer_low", low_len, DRIVE);
      check("speedup", {oe, out}, 2'b11);
      @(negedge i_core_clk);
      check("released", oe, 0);
      cmd.ack_pending = 1'b0;
      u_debug_host_model.drive_low(2);
      repeat (3) @(negedge i_core_clk);
      check("bit_after_sync", n_bit, 1);
    end
    // mid-run reset with the handshake on, cutting a bit at its end
    clr();
    u_debug_host_model.drive_low(3);
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_rst_b = 1'b1;
    check("handshake_rst2", hs_on, `SWD_HANDSHAKE_RST);
    check("oe_rst2", oe, 0);
    u_debug_host_model.drive_low(2);
    repeat (3) @(negedge i_core_clk);
    check("bit_after_rst", n_bit, 1);
    pulse(6'b000010);
    check("handshake_on2", hs_on, 1);
    pulse(6'b000001);
    check("handshake_off", hs_on, 0);
    wrap_up();
  end
endmodule // test_single_wire_debug_timeout
